// >>> design/hac_pkg.sv
// Package for the auxiliary HDLC channel configuration block.
// Assumes a 50 MHz system clock and an AXI4-Lite register master.
package hac_pkg;

  // Bus widths
  localparam int AW = 12;
  localparam int DW = 32;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_CH3_MODE = 10'h08f;
  localparam logic [9:0] IDX_PARITY = 10'h09b;
  localparam logic [9:0] IDX_TXQ2_LO = 10'h09c;
  localparam logic [9:0] IDX_TXQ2_HI = 10'h09d;
  localparam logic [9:0] IDX_TXQ3_LO = 10'h09e;
  localparam logic [9:0] IDX_TXQ3_HI = 10'h09f;
  localparam logic [9:0] IDX_ADDR_LO = 10'h0d0;
  localparam logic [9:0] IDX_ADDR_HI = 10'h0d1;
  localparam logic [9:0] IDX_STATUS = 10'h0d2;

  // Mode register fields and reset values
  localparam int MODE_SEL_LSB = 5;
  localparam int MODE_RXON = 3;
  localparam int MODE_INV = 2;
  localparam int MODE_SYS = 1;
  localparam logic [7:0] CH3_MODE_RESET = 8'h00;
  localparam logic [7:0] CH3_MODE_MASK = 8'hee;
  localparam logic [7:0] PARITY_RESET = 8'h00;
  localparam logic [7:0] PARITY_MASK = 8'h3f;
  localparam int PAR_CH2_LSB = 2;
  localparam int PAR_CH3_LSB = 4;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // Channel-3 mode select codes
  localparam logic [2:0] MDS_ADDR_LO = 3'h2;
  localparam logic [2:0] MDS_ADDR_BOTH = 3'h3;
  localparam logic [2:0] MDS_NONE = 3'h4;
  localparam logic [2:0] MDS_ADDR_HI = 3'h5;
  localparam logic [2:0] MDS_RAW = 3'h7;

  // Even/odd frame selection codes
  localparam logic [1:0] PAR_ALL = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;

  // Data path constants
  localparam logic [7:0] HDLC_FLAG = 8'h7e;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] WORD_LAST_BIT = 4'hf;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Receive framing states
  typedef enum logic [3:0] {
    RX_HUNT = 4'h1,
    RX_ADR1 = 4'h2,
    RX_ADR2 = 4'h4,
    RX_DATA = 4'h8
  } hac_rx_e;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } hac_axil_req_s;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DW-1:0] rdata;
    logic [1:0] rresp;
  } hac_axil_rsp_s;

endpackage

// >>> design/hac_top.sv
// Auxiliary HDLC channels 2 and 3: registers, transmit queues, bit paths.
// Assumes framer timing strobes on i_sys_clk and an AXI4-Lite master.
//
// Operation
// - Mode 101 filters frames on one address byte from the high register
// - Mode 111 runs channel 3 without any HDLC framing
// - Mode 100 accepts every received frame without address compare
// - Channel-3 receiver runs only while its receiver-on bit is 1
// - Invert bit set inverts every channel-3 generated data bit
// - Attach bit 0 connects channel 3 to the line side
// - Attach bit 1 receives from system input, sends on system output
// - Channel-3 queue word: low byte at 9E, high byte at 9F
// - Channel 2 has a write-only 16-bit transmit queue port
// - Frames 1, 3, ... are odd and frames 2, 4, ... are even
// - Every multiframe starts odd and ends even
// - One even/odd selection serves receive and transmit alike
// - Even/odd select register is zero after reset: all frames used
// - Per channel: 00 all, 01 odd, 10 even, 11 undefined
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Transmit word FIFO
module hac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_count
);
  import hac_pkg::*;
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } hac_fifo_s;
  hac_fifo_s q;
  hac_fifo_s d;
  logic push;
  logic pop;

  // Handshakes from the fill level
  assign o_in_ready = (q.cnt != (PW+1)'(DEPTH));
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data = q.mem[q.rd];
  assign o_count = q.cnt;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Pointers wrap naturally for a power-of-two depth
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = i_in_data;
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Register file and channel bit paths
module hac_top (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire hac_pkg::hac_axil_req_s i_axil,
  output hac_pkg::hac_axil_rsp_s o_axil,
  input wire logic i_bit_tick,
  input wire logic i_frame_start,
  input wire logic i_mframe_start,
  input wire logic i_line_rx_bit,
  input wire logic i_system_tx_data_in,
  output logic o_ch3_line_tx_bit,
  output logic o_system_rx_data_out,
  output logic o_ch2_tx_bit,
  output logic [7:0] o_rx_byte,
  output logic o_rx_byte_valid
);
  import hac_pkg::*;

  typedef struct packed {
    logic aw_full;
    logic [9:0] aw_idx;
    logic w_full;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DW-1:0] rdata;
    logic [1:0] rresp;
    logic [7:0] mode;
    logic [7:0] parity;
    logic [7:0] adr_lo;
    logic [7:0] adr_hi;
    logic [1:0][7:0] txq_lo;
    logic [2:0] sa;
    logic [2:0] sb;
    logic fa;
    logic fb;
    logic frame_odd;
    hac_rx_e rx_state;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic [1:0][WORD_W-1:0] tx_sh;
    logic [1:0][3:0] tx_left;
    logic [1:0] tx_bit;
    logic line_out;
    logic sys_out;
    logic ch2_out;
  } hac_top_s;

  hac_top_s q;
  hac_top_s d;
  logic [1:0] push_v;
  logic [1:0] push_rdy;
  logic [1:0] pop;
  logic [1:0] fifo_v;
  logic [1:0][WORD_W-1:0] fifo_data;
  logic [1:0][2:0] fifo_cnt;
  logic [1:0] tx_step;
  logic pend;
  logic commit;
  logic rx_on;
  logic rx_step;
  logic rx_src;
  logic [2:0] mds;
  logic [7:0] nsh;
  logic byte_done;
  logic flag_seen;
  logic ch3_bit;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Frame gate for one even/odd field; code 11 uses no frame
  function automatic logic frame_ok(input logic [1:0] sel,
                                    input logic odd);
    case (sel)
      PAR_ALL: frame_ok = 1'b1;
      PAR_ODD: frame_ok = odd;
      PAR_EVEN: frame_ok = !odd;
      default: frame_ok = 1'b0;
    endcase
  endfunction

  // Known register index
  function automatic logic mapped(input logic [9:0] idx);
    case (idx)
      IDX_CH3_MODE, IDX_PARITY, IDX_TXQ2_LO, IDX_TXQ2_HI, IDX_TXQ3_LO,
      IDX_TXQ3_HI, IDX_ADDR_LO, IDX_ADDR_HI, IDX_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Queues for channel 2 (index 0) and channel 3 (index 1)
  for (genvar c = 0; c < 2; c++) begin : g_q
    hac_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_in_valid(push_v[c]),
      .o_in_ready(push_rdy[c]),
      .i_in_data({q.w_data, q.txq_lo[c]}),
      .o_out_valid(fifo_v[c]),
      .i_out_ready(pop[c]),
      .o_out_data(fifo_data[c]),
      .o_count(fifo_cnt[c])
    );
  end

  // Mode decode and step strobes, one gate for both directions
  assign mds = q.mode[MODE_SEL_LSB+:3];
  assign rx_on = q.mode[MODE_RXON];
  assign tx_step[0] = i_bit_tick
    && frame_ok(q.parity[PAR_CH2_LSB+:2], q.frame_odd);
  assign tx_step[1] = i_bit_tick
    && frame_ok(q.parity[PAR_CH3_LSB+:2], q.frame_odd);
  assign rx_step = tx_step[1] && rx_on;
  assign rx_src = q.mode[MODE_SYS] ? q.fb : q.fa;
  assign nsh = {rx_src, q.rx_sh[7:1]};
  assign byte_done = (q.rx_cnt == BYTE_LAST_BIT);
  assign flag_seen = (nsh == HDLC_FLAG);
  assign ch3_bit = q.tx_bit[1] ^ q.mode[MODE_INV];

  // Write waits for a full queue, which back-pressures the master
  assign pend = q.aw_full && q.w_full && !q.bvalid;
  assign push_v[0] = pend && q.w_strb0 && (q.aw_idx == IDX_TXQ2_HI);
  assign push_v[1] = pend && q.w_strb0 && (q.aw_idx == IDX_TXQ3_HI);
  assign commit = pend && (!push_v[0] || push_rdy[0])
    && (!push_v[1] || push_rdy[1]);
  assign pop[0] = tx_step[0] && (q.tx_left[0] == '0) && fifo_v[0];
  assign pop[1] = tx_step[1] && (q.tx_left[1] == '0) && fifo_v[1];

  // Bus answers
  assign o_axil.awready = !q.aw_full;
  assign o_axil.wready = !q.w_full;
  assign o_axil.bvalid = q.bvalid;
  assign o_axil.bresp = q.bresp;
  assign o_axil.arready = !q.rvalid;
  assign o_axil.rvalid = q.rvalid;
  assign o_axil.rdata = q.rdata;
  assign o_axil.rresp = q.rresp;

  // Pin outputs
  assign o_ch3_line_tx_bit = q.line_out;
  assign o_system_rx_data_out = q.sys_out;
  assign o_ch2_tx_bit = q.ch2_out;
  assign o_rx_byte = q.rx_byte;
  assign o_rx_byte_valid = q.rx_valid;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    d.rx_valid = 1'b0;

    // Write address and data are taken in either order
    if (i_axil.awvalid && !q.aw_full) begin
      d.aw_full = 1'b1;
      d.aw_idx = i_axil.awaddr[AW-1:2];
    end
    if (i_axil.wvalid && !q.w_full) begin
      d.w_full = 1'b1;
      d.w_data = i_axil.wdata[7:0];
      d.w_strb0 = i_axil.wstrb[0];
    end
    if (q.bvalid && i_axil.bready) begin
      d.bvalid = 1'b0;
    end

    // Register write; a high queue byte pushes the word
    if (commit) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      if (q.w_strb0) begin
        case (q.aw_idx)
          IDX_CH3_MODE: d.mode = q.w_data & CH3_MODE_MASK;
          IDX_PARITY: d.parity = q.w_data & PARITY_MASK;
          IDX_ADDR_LO: d.adr_lo = q.w_data;
          IDX_ADDR_HI: d.adr_hi = q.w_data;
          IDX_TXQ2_LO: d.txq_lo[0] = q.w_data;
          IDX_TXQ3_LO: d.txq_lo[1] = q.w_data;
          default: d.mode = q.mode;
        endcase
      end
    end

    // Register read; queue ports are write-only and read zero
    if (q.rvalid && i_axil.rready) begin
      d.rvalid = 1'b0;
    end
    if (i_axil.arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = '0;
      d.rresp = mapped(i_axil.araddr[AW-1:2]) ? RESP_OKAY : RESP_SLVERR;
      case (i_axil.araddr[AW-1:2])
        IDX_CH3_MODE: d.rdata[7:0] = q.mode;
        IDX_PARITY: d.rdata[7:0] = q.parity;
        IDX_ADDR_LO: d.rdata[7:0] = q.adr_lo;
        IDX_ADDR_HI: d.rdata[7:0] = q.adr_hi;
        IDX_STATUS: d.rdata[7:0] = {(q.rx_state != RX_HUNT), q.frame_odd,
                                    fifo_cnt[1], fifo_cnt[0]};
        default: d.rdata = '0;
      endcase
    end

    // Pin synchronisers; a change counts once stages two and three agree
    d.sa = {q.sa[1:0], i_line_rx_bit};
    d.sb = {q.sb[1:0], i_system_tx_data_in};
    if (q.sa[1] == q.sa[2]) begin
      d.fa = q.sa[2];
    end
    if (q.sb[1] == q.sb[2]) begin
      d.fb = q.sb[2];
    end

    // Frame parity; multiframe opens odd, frames alternate
    if (i_mframe_start) begin
      d.frame_odd = 1'b1;
    end else if (i_frame_start) begin
      d.frame_odd = !q.frame_odd;
    end

    // Channel-3 receiver
    if (!rx_on) begin
      d.rx_state = RX_HUNT;
      d.rx_cnt = '0;
    end else if (rx_step) begin
      d.rx_sh = nsh;
      d.rx_cnt = q.rx_cnt + 3'h1;
      if (mds == MDS_RAW) begin
        d.rx_state = RX_DATA;
        if (byte_done) begin
          d.rx_byte = nsh;
          d.rx_valid = 1'b1;
        end
      end else if (flag_seen) begin
        d.rx_state = RX_ADR1;
        d.rx_cnt = '0;
      end else if (byte_done) begin
        case (q.rx_state)
          RX_ADR1: begin
            case (mds)
              MDS_NONE: begin
                d.rx_state = RX_DATA;
                d.rx_byte = nsh;
                d.rx_valid = 1'b1;
              end
              MDS_ADDR_LO: begin
                d.rx_state = (nsh == q.adr_lo) ? RX_DATA : RX_HUNT;
              end
              MDS_ADDR_BOTH: begin
                d.rx_state = (nsh == q.adr_hi) ? RX_ADR2 : RX_HUNT;
              end
              MDS_ADDR_HI: begin
                d.rx_state = (nsh == q.adr_hi) ? RX_DATA : RX_HUNT;
              end
              default: d.rx_state = RX_HUNT;
            endcase
          end
          RX_ADR2: begin
            d.rx_state = (nsh == q.adr_lo) ? RX_DATA : RX_HUNT;
          end
          RX_DATA: begin
            d.rx_byte = nsh;
            d.rx_valid = 1'b1;
          end
          RX_HUNT: d.rx_state = RX_HUNT;
          default: d.rx_state = RX_HUNT;
        endcase
      end
    end

    // Serialisers, LSB first, mark idle when the queue is empty
    for (int c = 0; c < 2; c++) begin
      if (tx_step[c]) begin
        if (q.tx_left[c] != '0) begin
          d.tx_bit[c] = q.tx_sh[c][0];
          d.tx_sh[c] = {1'b0, q.tx_sh[c][WORD_W-1:1]};
          d.tx_left[c] = q.tx_left[c] - 4'h1;
        end else if (fifo_v[c]) begin
          d.tx_bit[c] = fifo_data[c][0];
          d.tx_sh[c] = {1'b0, fifo_data[c][WORD_W-1:1]};
          d.tx_left[c] = WORD_LAST_BIT;
        end else begin
          d.tx_bit[c] = 1'b1;
        end
      end
    end

    // Output routing of channel 3
    d.line_out = q.mode[MODE_SYS] ? 1'b1 : ch3_bit;
    d.sys_out = q.mode[MODE_SYS] ? ch3_bit : 1'b1;
    d.ch2_out = q.tx_bit[0];
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
      q.mode <= CH3_MODE_RESET;
      q.parity <= PARITY_RESET;
      q.adr_lo <= ADDR_RESET;
      q.adr_hi <= ADDR_RESET;
      q.frame_odd <= 1'b1;
      q.rx_state <= RX_HUNT;
      q.tx_bit <= '1;
      q.line_out <= 1'b1;
      q.sys_out <= 1'b1;
      q.ch2_out <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence seq_adr1_byte;
    rx_step && (q.rx_state == RX_ADR1) && byte_done && !flag_seen;
  endsequence

  chk_addr_hi_filter: assert property (
    seq_adr1_byte ##0 (mds == MDS_ADDR_HI) ##0 (nsh != q.adr_hi)
    |=> (q.rx_state == RX_HUNT) && !o_rx_byte_valid)
    else $error("high address mismatch did not drop the frame");

  chk_raw_no_hunt: assert property (
    (rx_step && (mds == MDS_RAW)) |=> (q.rx_state == RX_DATA))
    else $error("unframed mode still hunts for flags");

  chk_accept_all: assert property (
    seq_adr1_byte ##0 (mds == MDS_NONE)
    |=> (q.rx_state == RX_DATA) && o_rx_byte_valid)
    else $error("accept-all mode rejected a frame");

  chk_rx_off_idle: assert property (
    !rx_on |=> (q.rx_state == RX_HUNT) && !o_rx_byte_valid)
    else $error("receiver ran while switched off");

  chk_line_invert: assert property (
    (!q.mode[MODE_SYS] && q.mode[MODE_INV])
    |=> o_ch3_line_tx_bit != $past(q.tx_bit[1]))
    else $error("channel-3 line bit not inverted");

  chk_line_attach: assert property (
    !q.mode[MODE_SYS] |=> (o_ch3_line_tx_bit == $past(ch3_bit))
    && o_system_rx_data_out)
    else $error("channel 3 not on the line side");

  chk_sys_attach: assert property (
    q.mode[MODE_SYS] |=> (o_system_rx_data_out == $past(ch3_bit))
    && o_ch3_line_tx_bit)
    else $error("channel 3 not on the system side");

  chk_queue_push: assert property (
    (push_v[1] && push_rdy[1]) |=> o_axil.bvalid
    && (g_q[1].u_fifo.o_count != '0))
    else $error("high queue byte did not complete a word");

  chk_parity_first: assert property (
    i_mframe_start |=> q.frame_odd)
    else $error("multiframe did not open with an odd frame");

  chk_parity_toggle: assert property (
    (i_frame_start && !i_mframe_start)
    |=> q.frame_odd != $past(q.frame_odd))
    else $error("frame parity did not alternate");

  chk_frame_gate: assert property (
    (i_bit_tick && (q.parity[PAR_CH3_LSB+:2] == PAR_EVEN) && q.frame_odd)
    |=> $stable(q.tx_sh[1]) && $stable(q.rx_sh))
    else $error("channel 3 moved in an odd frame under even-only");
endmodule

`default_nettype wire

// >>> tb/hac_line_model.sv
// Far-side model: framer strobes and the bit stream toward channel 3.
// Assumes the bench pushes bytes and picks line or system side.
`timescale 1ns/10ps
`default_nettype none
module hac_line_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_push,
  input wire logic [7:0] i_byte,
  input wire logic i_to_sys,
  input wire logic [1:0] i_code,
  output logic o_idle,
  output logic o_tick,
  output logic o_frame,
  output logic o_mframe,
  output logic o_line,
  output logic o_sys
);
  logic [8:0] c;
  logic [511:0] sh;
  logic odd;
  logic ok;
  logic b;
  int n;
  // Ticks every 8 cycles, 16 ticks a frame, 4 frames a multiframe
  assign o_tick = (c[2:0] == 3'h0);
  assign o_frame = (c[6:0] == 7'h01) && (c[8:7] != 2'h0);
  assign o_mframe = (c[8:0] == 9'h001);
  assign o_idle = (n == 0);
  // New bit set well ahead of the next tick; foreign frames get noise
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c <= 9'h000;
      odd <= 1'b1;
      n = 0;
      b = 1'b1;
      o_line <= 1'b1;
      o_sys <= 1'b1;
    end else begin
      c <= c + 9'h001;
      if (o_mframe) odd <= 1'b1;
      else if (o_frame) odd <= !odd;
      if (c[2:0] == 3'h2) begin
        ok = (i_code == 2'h0) || (i_code == 2'h1 && odd) ||
             (i_code == 2'h2 && !odd);
        if (!ok) b = !b;
        else if (n > 0) begin
          b = sh[0];
          sh = sh >> 1;
          n = n - 1;
        end else b = 1'b1;
        o_line <= i_to_sys ? !o_line : b;
        o_sys <= i_to_sys ? b : !o_sys;
      end
      if (i_push) begin
        sh[n +: 8] = i_byte;
        n = n + 8;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/hac_top_tb_top.sv
// Self-checking bench for the auxiliary channel block.
// Assumes the line model file is compiled beside it.
`timescale 1ns/10ps
`default_nettype none
module hac_top_tb_top;
  import hac_pkg::*;
  logic clk, rst_n, tick, fr, mf, line, sys, l3, s3, t2, rv, cbit;
  logic push, tosys, idle, idl;
  logic [7:0] pb, rb, ral, rah;
  logic [1:0] mcode, csel, ccode;
  logic [2:0] ap;
  logic [31:0] seed, v;
  logic [127:0] cap;
  hac_axil_req_s rq;
  hac_axil_rsp_s rs;
  logic [7:0] rxq[$];
  int fails, checked, capn, ctot, cyc, k;

  hac_top uut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_axil(rq),
    .o_axil(rs), .i_bit_tick(tick), .i_frame_start(fr),
    .i_mframe_start(mf), .i_line_rx_bit(line),
    .i_system_tx_data_in(sys), .o_ch3_line_tx_bit(l3),
    .o_system_rx_data_out(s3), .o_ch2_tx_bit(t2), .o_rx_byte(rb),
    .o_rx_byte_valid(rv));
  hac_line_model far (.i_clk(clk), .i_rst_n(rst_n), .i_push(push),
    .i_byte(pb), .i_to_sys(tosys), .i_code(mcode), .o_idle(idle),
    .o_tick(tick), .o_frame(fr), .o_mframe(mf), .o_line(line),
    .o_sys(sys));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  assign cbit = (csel == 2'h0) ? t2 : (csel == 2'h1) ? l3 : s3;

  // Frame parity, transmit bit capture, received bytes, timeout
  logic todd = 1'b1;
  always @(posedge clk) begin
    if (mf) todd <= 1'b1;
    else if (fr) todd <= !todd;
    ap <= {ap[1:0], tick && (ccode == 2'h0 || (ccode == 2'h1 && todd)
          || (ccode == 2'h2 && !todd))};
    if (ap[2] && capn < ctot && (capn != 0 || cbit !== idl)) begin
      cap[capn] = cbit;
      capn = capn + 1;
    end
    if (rv) rxq.push_back(rb);
    cyc = cyc + 1;
    if (cyc > 60000) begin
      fails = fails + 1;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Random byte that can never look like a flag
  function automatic logic [7:0] nb();
    logic [31:0] t;
    t = xs() & 32'h3d;
    return t[7:0];
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked = checked + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // AXI4-Lite write: both channels offered, each dropped when taken
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= d;
    rq.wstrb <= 4'hf;
    rq.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
      if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
    end while (!rs.bvalid);
    rq.bready <= 1'b0;
    chk(rs.bresp, er);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
    end while (!rs.rvalid);
    rq.rready <= 1'b0;
    chk(rs.rresp, er);
    if (er == 2'h0) chk(rs.rdata, e);
  endtask
  // Queue nw words and compare the bits seen on allowed steps
  task txw(input logic [11:0] a, input logic [1:0] s, input logic [1:0] c,
           input logic inv, input int nw);
    logic [127:0] w;
    int i;
    ctot = 0;
    csel = s;
    ccode = c;
    // Idle is mark, inverted along with the stream; wait until it shows
    idl = !inv;
    w = {xs(), xs(), xs(), xs()};
    w[0] = !idl ^ inv;
    repeat (600) if (cbit !== idl) @(posedge clk);
    ctot = nw * 16;
    capn = 0;
    for (i = 0; i < nw; i++) begin
      wr(a, {24'h0, w[16*i +: 8]}, 2'h0);
      wr(a + 12'h4, {24'h0, w[16*i+8 +: 8]}, 2'h0);
    end
    repeat (6000) if (capn < ctot) @(posedge clk);
    w = w ^ {128{inv}};
    for (i = 0; i < nw; i++) chk(cap[16*i +: 16], w[16*i +: 16]);
  endtask
  // Send flag, two header bytes, two data bytes, flag; ne bytes expected
  task rx(input logic [2:0] m, input logic on, input logic sy,
          input logic [7:0] a1, input logic [7:0] a2, input int ne);
    logic [7:0] f[6];
    int i;
    f = '{8'h7e, a1, a2, nb(), nb(), 8'h7e};
    wr(12'h23c, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    rxq.delete();
    tosys <= sy;
    wr(12'h23c, {24'h0, m, 1'b0, on, 1'b0, sy, 1'b0}, 2'h0);
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      push <= 1'b1;
      pb <= f[i];
    end
    @(posedge clk);
    push <= 1'b0;
    repeat (8000) if (!idle) @(posedge clk);
    repeat (300) @(posedge clk);
    chk(rxq.size() >= ne && (ne > 0 || rxq.size() == 0), 1);
    for (i = 0; i < ne; i++) chk(rxq[i], f[5-ne+i]);
  endtask
  task close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rq = '0;
    rst_n = 1'b0;
    {push, tosys, pb, mcode, csel, ccode, ap, idl} = '0;
    {fails, checked, capn, ctot, cyc} = '0;
    seed = 32'h14;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h23c, 32'h0, 2'h0);
    rd(12'h26c, 32'h0, 2'h0);
    rd(12'h27c, 32'h0, 2'h0);
    rd(12'h270, 32'h0, 2'h0);
    rd(12'h000, 32'h0, 2'h2);
    wr(12'h000, 32'h5a, 2'h2);
    v = xs();
    wr(12'h23c, v, 2'h0);
    rd(12'h23c, v & 32'hee, 2'h0);
    v = xs();
    wr(12'h26c, v, 2'h0);
    rd(12'h26c, v & 32'h3f, 2'h0);
    ral = nb();
    rah = ral ^ 8'h40;
    wr(12'h340, {24'h0, ral}, 2'h0);
    wr(12'h344, {24'h0, rah}, 2'h0);
    rd(12'h344, {24'h0, rah}, 2'h0);
    for (k = 0; k < 3; k++) begin
      wr(12'h26c, 32'(k) << 2, 2'h0);
      txw(12'h270, 2'h0, 2'(k), 1'b0, k == 0 ? 6 : 2);
    end
    wr(12'h26c, 32'h0, 2'h0);
    for (k = 0; k < 4; k++) begin
      wr(12'h23c, {24'h0, 3'h4, 2'h0, k[0], k[1], 1'b0}, 2'h0);
      txw(12'h278, k[1] ? 2'h2 : 2'h1, 2'h0, k[0], 1);
      chk(k[1] ? l3 : s3, 1);
    end
    rx(3'h4, 1'b1, 1'b0, nb(), nb(), 4);
    rx(3'h4, 1'b0, 1'b0, nb(), nb(), 0);
    rx(3'h4, 1'b1, 1'b1, nb(), nb(), 4);
    rx(3'h2, 1'b1, 1'b0, ral, nb(), 3);
    rx(3'h2, 1'b1, 1'b0, ral ^ 8'h01, nb(), 0);
    rx(3'h3, 1'b1, 1'b0, rah, ral, 2);
    rx(3'h5, 1'b1, 1'b0, rah, nb(), 3);
    rx(3'h5, 1'b1, 1'b0, ral, nb(), 0);
    rx(3'h0, 1'b1, 1'b0, nb(), nb(), 0);
    rx(3'h1, 1'b1, 1'b0, nb(), nb(), 0);
    rx(3'h6, 1'b1, 1'b0, nb(), nb(), 0);
    wr(12'h23c, 32'h0, 2'h0);
    rxq.delete();
    wr(12'h23c, 32'he8, 2'h0);
    repeat (300) @(posedge clk);
    chk(rxq.size() >= 3, 1);
    chk(rxq[0], 8'hff);
    wr(12'h26c, 32'h20, 2'h0);
    mcode <= 2'h2;
    rx(3'h4, 1'b1, 1'b0, nb(), nb(), 4);
    close_out();
  end
endmodule
`default_nettype wire
